//--- ldriu_bank.v
// Lane delay register bank behind the register interface unit.
// Assumes fabric logic drives one-cycle write/read strobes on mclk.
// Operation
// - Lane-5 codes 000,011,100,111 load the written delay value directly.
// - Code 001 adds one tap, 0x1ff wraps to 0.
// - Code 010 subtracts one tap, 0 wraps to 0x1ff.
// - Code 101 adds the step tap count modulo 512.
// - Code 110 subtracts the step tap count modulo 512.
// - Direct register load equals a fabric delay-load on bits 53:45.
// - Down, up, step select at bits 14,15,13; write-only, reset zero.
// - Coarse controls 00 or 11 load the written coarse value directly.
// - Coarse code 10 adds one tap, 0x1f wraps to 0.
// - Coarse code 01 subtracts one tap, 0 wraps to top of field.
// - Coarse value bits 4:0 read-write; down/up write-only at 14,15.
// - Training bit 1 acts as the drift-compensation enable.
// - Training bit 7 set pauses self-calibration; clear resumes it.
// - Read-idle count, 6 bits reset 0x10, delays termination disable.
// - Step tap count is an 8-bit field defaulting to 0x08.
// - Lane-5 delay in bits 8:0 includes alignment, never changes it; the code ignores lane5_align_offset, bits 8:0 hold lane5_q only.
`timescale 1ns/10ps
`default_nettype none
`include "ldriu_defines.vh"
module ldriu_bank #(
   parameter ADDR_W = 8,
   parameter ALIGN_W = 9,
   parameter RST_ALIGN = 9'h000
) (
   // Clock and reset
   input wire mclk,
   input wire arst_n,
   // Register interface unit
   input wire [ADDR_W-1:0] riu_addr,
   input wire [15:0] riu_wr_data,
   input wire riu_wr_en,
   input wire riu_rd_en,
   output reg [15:0] riu_rd_data,
   output reg riu_rd_valid,
   // Fabric delay load path for lane 5
   input wire fabric_delay_load,
   input wire [8:0] fabric_delay_load_bus,
   // Slice-side controls and status
   input wire [ALIGN_W-1:0] lane5_align_offset,
   input wire rx_div_tick,
   input wire read_active,
   output reg [8:0] lane5_delay_value,
   output reg [4:0] coarse_delay_value,
   output reg drift_comp_enable,
   output reg calibration_pause,
   output reg termination_enable
);
   // Reset synchroniser, released through two flops
   reg rst_meta_q;
   reg rst_sync_q;
   wire rst_n;
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   // Address decode shared by read and write paths
   function hit;
      input [ADDR_W-1:0] a;
      input [7:0] target;
      begin
         hit = (a == target[ADDR_W-1:0]);
      end
   endfunction

   wire wr_lane5 = riu_wr_en && hit(riu_addr, `LDRIU_ADDR_LANE5_DELAY);
   wire wr_coarse = riu_wr_en && hit(riu_addr, `LDRIU_ADDR_COARSE_DELAY);
   wire wr_train = riu_wr_en && hit(riu_addr, `LDRIU_ADDR_TRAINING);
   wire wr_idle = riu_wr_en && hit(riu_addr, `LDRIU_ADDR_READ_IDLE);
   wire wr_step = riu_wr_en && hit(riu_addr, `LDRIU_ADDR_STEP_SIZE);

   // Write-only controls are never stored; they only pick the update
   wire [2:0] lane5_code = {riu_wr_data[`LDRIU_BIT_STEP_SEL], riu_wr_data[`LDRIU_BIT_DOWN],
      riu_wr_data[`LDRIU_BIT_UP]};
   wire l5_inc1 = (lane5_code == `LDRIU_CODE_INC1);
   wire l5_dec1 = (lane5_code == `LDRIU_CODE_DEC1);
   wire l5_incn = (lane5_code == `LDRIU_CODE_INCN);
   wire l5_decn = (lane5_code == `LDRIU_CODE_DECN);
   wire l5_stepping = l5_inc1 | l5_dec1 | l5_incn | l5_decn;
   wire c_up = riu_wr_data[`LDRIU_BIT_UP];
   wire c_down = riu_wr_data[`LDRIU_BIT_DOWN];

   // Stored registers
   reg [8:0] lane5_q;
   reg [4:0] coarse_q;
   reg drift_q;
   reg pause_q;
   reg [5:0] idle_q;
   reg [7:0] step_q;
   reg [5:0] idle_cnt_q;
   reg term_q;

   // Request latched one cycle so the step lands the cycle after the write
   reg l5_req_q;
   reg l5_inc_q;
   reg l5_dec_q;
   reg l5_big_q;
   reg c_req_q;
   reg c_inc_q;

   wire [8:0] l5_step = l5_big_q ? {1'b0, step_q} : 9'h001;
   wire [8:0] l5_next;
   wire [4:0] c_next;

   // Shared modulo stepper for lane 5
   ldriu_delay_step #(
      .WIDTH(9)
   ) u_lane5_step (
      .cur_value(lane5_q),
      .step(l5_step),
      .inc(l5_inc_q),
      .dec(l5_dec_q),
      .next_value(l5_next)
   );

   // Coarse stepper; 5-bit field so 0 wraps to 0x1f, the field's top
   ldriu_delay_step #(
      .WIDTH(5)
   ) u_coarse_step (
      .cur_value(coarse_q),
      .step(5'h01),
      .inc(c_inc_q),
      .dec(!c_inc_q),
      .next_value(c_next)
   );

   // Update requests, captured for exactly one cycle
   // Step kind is kept even without a request; it only matters with l5_req_q
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         l5_req_q <= 1'b0;
         l5_inc_q <= 1'b0;
         l5_dec_q <= 1'b0;
         l5_big_q <= 1'b0;
         c_req_q <= 1'b0;
         c_inc_q <= 1'b0;
      end else begin
         l5_req_q <= wr_lane5 && l5_stepping;
         l5_inc_q <= wr_lane5 && (l5_inc1 || l5_incn);
         l5_dec_q <= wr_lane5 && (l5_dec1 || l5_decn);
         l5_big_q <= l5_incn || l5_decn;
         c_req_q <= wr_coarse && (c_up != c_down);
         c_inc_q <= c_up;
      end
   end

   // Lane-5 next value; a direct write beats a step landing the same cycle
   reg [8:0] lane5_d;
   always @* begin
      lane5_d = lane5_q;
      if (wr_lane5 && !l5_stepping) begin
         lane5_d = riu_wr_data[`LDRIU_LANE5_DLY_MSB:0];
      end else if (l5_req_q) begin
         lane5_d = l5_next;
      end else if (fabric_delay_load) begin
         // Fabric load yields to register traffic, so a bus update landing with a direct write or step is lost
         lane5_d = fabric_delay_load_bus;
      end
   end

   // Lane-5 delay; alignment offset is an input and is never written here
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lane5_q <= `LDRIU_RST_LANE5_DELAY;
      end else begin
         lane5_q <= lane5_d;
      end
   end

   // Coarse next value; reserved bits 13:5 of a write are simply dropped
   reg [4:0] coarse_d;
   always @* begin
      coarse_d = coarse_q;
      // A step landing with a direct write is lost; the write wins
      if (wr_coarse && (c_up == c_down)) begin
         coarse_d = riu_wr_data[`LDRIU_COARSE_MSB:0];
      end else if (c_req_q) begin
         coarse_d = c_next;
      end
   end

   // Coarse delay
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         coarse_q <= `LDRIU_RST_COARSE;
      end else begin
         coarse_q <= coarse_d;
      end
   end

   // Next values of the training, idle count and step size fields
   reg drift_d;
   reg pause_d;
   reg [5:0] idle_d;
   reg [7:0] step_d;
   always @* begin
      drift_d = drift_q;
      pause_d = pause_q;
      idle_d = idle_q;
      step_d = step_q;
      // Only defined bits are kept; the rest read back as zero
      if (wr_train) begin
         drift_d = riu_wr_data[`LDRIU_BIT_DRIFT_EN];
         pause_d = riu_wr_data[`LDRIU_BIT_CAL_PAUSE];
      end
      if (wr_idle) begin
         idle_d = riu_wr_data[`LDRIU_IDLE_MSB:0];
      end
      if (wr_step) begin
         step_d = riu_wr_data[`LDRIU_STEP_MSB:0];
      end
   end

   // Training, idle count and step size registers
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         drift_q <= 1'b0;
         pause_q <= 1'b0;
         idle_q <= `LDRIU_RST_IDLE;
         step_q <= `LDRIU_RST_STEP;
      end else begin
         drift_q <= drift_d;
         pause_q <= pause_d;
         idle_q <= idle_d;
         step_q <= step_d;
      end
   end

   // Termination off on the tick after idle_q divided-clock ticks with no read
   reg [5:0] idle_cnt_d;
   reg term_d;
   always @* begin
      idle_cnt_d = idle_cnt_q;
      term_d = term_q;
      // A read arriving on the last tick keeps termination on
      if (read_active) begin
         idle_cnt_d = 6'h00;
         term_d = 1'b1;
      end else if (term_q && rx_div_tick) begin
         if (idle_cnt_q >= idle_q) begin
            term_d = 1'b0;
         end else begin
            idle_cnt_d = idle_cnt_q + 6'h01;
         end
      end
   end

   // Termination state; a new read restarts the count rather than extending it
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         idle_cnt_q <= 6'h00;
         term_q <= 1'b0;
      end else begin
         idle_cnt_q <= idle_cnt_d;
         term_q <= term_d;
      end
   end

   // Read mux; write-only and reserved bits return zero
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         riu_rd_data <= 16'h0000;
         riu_rd_valid <= 1'b0;
      end else begin
         riu_rd_valid <= riu_rd_en;
         riu_rd_data <= 16'h0000;
         if (riu_rd_en) begin
            if (hit(riu_addr, `LDRIU_ADDR_LANE5_DELAY)) begin
               riu_rd_data <= {7'h00, lane5_q};
            end else if (hit(riu_addr, `LDRIU_ADDR_COARSE_DELAY)) begin
               riu_rd_data <= {11'h000, coarse_q};
            end else if (hit(riu_addr, `LDRIU_ADDR_TRAINING)) begin
               riu_rd_data <= {8'h00, pause_q, 5'h00, drift_q, 1'b0};
            end else if (hit(riu_addr, `LDRIU_ADDR_READ_IDLE)) begin
               riu_rd_data <= {10'h000, idle_q};
            end else if (hit(riu_addr, `LDRIU_ADDR_STEP_SIZE)) begin
               riu_rd_data <= {8'h00, step_q};
            end
         end
      end
   end

   // Registered outputs to the slice
   always @* begin
      lane5_delay_value = lane5_q;
      coarse_delay_value = coarse_q;
      drift_comp_enable = drift_q;
      calibration_pause = pause_q;
      termination_enable = term_q;
   end
endmodule // ldriu_bank
`default_nettype wire

//--- ldriu_defines.vh
// Register map, field positions and reset values for the lane delay register bank.
// Included by the bank only; the update helper does not use it; definitions only.
`ifndef LDRIU_DEFINES_VH
`define LDRIU_DEFINES_VH

// Register offsets on the register interface unit address
`define LDRIU_ADDR_LANE5_DELAY 8'h17
`define LDRIU_ADDR_COARSE_DELAY 8'h18
`define LDRIU_ADDR_TRAINING 8'h2b
`define LDRIU_ADDR_READ_IDLE 8'h34
`define LDRIU_ADDR_STEP_SIZE 8'h3b

// Field positions
`define LDRIU_LANE5_DLY_MSB 8
`define LDRIU_COARSE_MSB 4
`define LDRIU_BIT_STEP_SEL 13
`define LDRIU_BIT_DOWN 14
`define LDRIU_BIT_UP 15
`define LDRIU_BIT_DRIFT_EN 1
`define LDRIU_BIT_CAL_PAUSE 7
`define LDRIU_IDLE_MSB 5
`define LDRIU_STEP_MSB 7

// Reset values
`define LDRIU_RST_LANE5_DELAY 9'h000
`define LDRIU_RST_COARSE 5'h00
`define LDRIU_RST_IDLE 6'h10
`define LDRIU_RST_STEP 8'h08

// Lane-5 update codes {step select, down, up}
`define LDRIU_CODE_INC1 3'h1
`define LDRIU_CODE_DEC1 3'h2
`define LDRIU_CODE_INCN 3'h5
`define LDRIU_CODE_DECN 3'h6

`endif

//--- ldriu_delay_step.v
// Computes the next value of a wrapping delay counter from an update code.
// Pure combinational; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none
module ldriu_delay_step #(
   parameter WIDTH = 9
) (
   // Current value and request
   input wire [WIDTH-1:0] cur_value,
   input wire [WIDTH-1:0] step,
   input wire inc,
   input wire dec,
   // Next value
   output reg [WIDTH-1:0] next_value
);
   // Modulo arithmetic gives the documented wraparound for free
   always @* begin
      if (inc) begin
         next_value = cur_value + step;
      end else if (dec) begin
         next_value = cur_value - step;
      end else begin
         next_value = cur_value;
      end
   end
endmodule // ldriu_delay_step
`default_nettype wire

//--- ldriu_fabric_model.sv
// Fabric-side model: divided receive-clock tick.
// Assumes the bench's mclk; one-cycle pulse every DIV cycles.
`timescale 1ns/10ps
`default_nettype none
module ldriu_fabric_model #(parameter int DIV = 4) (
   // Clock, reset and tick
   input wire logic mclk,
   input wire logic arst_n,
   output logic rx_div_tick
);
   logic [7:0] cnt_q;
   // Runs free, as a PLL-derived divider does
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) cnt_q <= 8'h00;
      else cnt_q <= (cnt_q == 8'(DIV - 1)) ? 8'h00 : cnt_q + 8'h01;
   end
   assign rx_div_tick = (cnt_q == 8'(DIV - 1));
endmodule // ldriu_fabric_model
`default_nettype wire

//--- ldriu_properties.sv
// Port-level checks for the lane delay register bank.
// Assumes one mclk domain; bound to every bank instance.
`timescale 1ns/10ps
`default_nettype none
module ldriu_properties #(parameter ADDR_W = 8) (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Register interface unit
   input wire logic [ADDR_W-1:0] riu_addr,
   input wire logic [15:0] riu_wr_data,
   input wire logic riu_wr_en,
   input wire logic [15:0] riu_rd_data,
   input wire logic riu_rd_valid,
   // Delay and training outputs
   input wire logic [8:0] lane5_delay_value,
   input wire logic [4:0] coarse_delay_value,
   input wire logic drift_comp_enable,
   input wire logic calibration_pause
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   logic [7:0] step_q;
   // Write decodes and short aliases
   wire w5 = riu_wr_en && riu_addr == 8'h17;
   wire wc = riu_wr_en && riu_addr == 8'h18;
   wire [2:0] c5 = {riu_wr_data[13], riu_wr_data[14], riu_wr_data[15]};
   wire [1:0] cc = {riu_wr_data[15], riu_wr_data[14]};
   wire [8:0] l5 = lane5_delay_value;
   wire [4:0] cd = coarse_delay_value;
   // Step count mirror, so large steps can be predicted
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) step_q <= 8'h08;
      else if (riu_wr_en && riu_addr == 8'h3b) step_q <= riu_wr_data[7:0];
   end
   property p_l5_load; w5 && (c5[1] == c5[0]) |=>
      l5 == $past(riu_wr_data[8:0]); endproperty
   a_l5_load: assert property (p_l5_load) else $error("lane5 load");
   property p_l5_inc; w5 && c5 == 3'h1 |=> ##1 l5 == $past(l5, 2) + 9'h1; endproperty
   a_l5_inc: assert property (p_l5_inc) else $error("lane5 up");
   property p_l5_dec; w5 && c5 == 3'h2 |=> ##1 l5 == $past(l5, 2) - 9'h1; endproperty
   a_l5_dec: assert property (p_l5_dec) else $error("lane5 down");
   property p_l5_incn; w5 && c5 == 3'h5 |=> ##1 l5 == $past(l5, 2) + {1'b0, step_q}; endproperty
   a_l5_incn: assert property (p_l5_incn) else $error("lane5 big up");
   property p_l5_decn; w5 && c5 == 3'h6 |=> ##1 l5 == $past(l5, 2) - {1'b0, step_q}; endproperty
   a_l5_decn: assert property (p_l5_decn) else $error("lane5 big down");
   property p_crs_load; wc && cc[1] == cc[0] |=> cd == $past(riu_wr_data[4:0]); endproperty
   a_crs_load: assert property (p_crs_load) else $error("coarse load");
   property p_crs_inc; wc && cc == 2'b10 |=> ##1 cd == $past(cd, 2) + 5'h1; endproperty
   a_crs_inc: assert property (p_crs_inc) else $error("coarse up");
   property p_crs_dec; wc && cc == 2'b01 |=> ##1 cd == $past(cd, 2) - 5'h1; endproperty
   a_crs_dec: assert property (p_crs_dec) else $error("coarse down");
   property p_train; riu_wr_en && riu_addr == 8'h2b |=> drift_comp_enable ==
      $past(riu_wr_data[1]) && calibration_pause == $past(riu_wr_data[7]); endproperty
   a_train: assert property (p_train) else $error("training bits");
   property p_rd_zero; !riu_rd_valid |-> riu_rd_data == 16'h0000; endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("idle read data");
endmodule // ldriu_properties
bind ldriu_bank ldriu_properties #(.ADDR_W(ADDR_W)) u_props (.*);
`default_nettype wire

//--- tb.sv
// Self-checking bench for the lane delay register bank.
// Assumes the fabric model paces the divided receive tick.
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic mclk = 1'b0, arst_n = 1'b0, riu_wr_en = 1'b0, riu_rd_en = 1'b0;
   logic fabric_delay_load = 1'b0, read_active = 1'b0;
   logic [7:0] riu_addr = 8'h00, st = 8'h08;
   logic [15:0] riu_wr_data = 16'h0000, rv;
   logic [8:0] fabric_delay_load_bus = 9'h000, v;
   logic [4:0] b;
   logic [2:0] c;
   logic [1:0] k;
   logic [2:0] cdt [8] = '{3'h0, 3'h3, 3'h4, 3'h7, 3'h1, 3'h2, 3'h5, 3'h6};
   logic [31:0] seed = 32'hec2c;
   wire [15:0] riu_rd_data;
   wire [8:0] lane5_delay_value;
   wire [4:0] coarse_delay_value;
   wire riu_rd_valid, rx_div_tick, drift_comp_enable, calibration_pause, termination_enable;
   int fails = 0, n_compared = 0, i, n;
   always #5 mclk = ~mclk;
   ldriu_bank u_dut (.*, .lane5_align_offset(9'h0aa));
   ldriu_fabric_model u_fab (.mclk(mclk), .arst_n(arst_n), .rx_div_tick(rx_div_tick));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Expected lane-5 value after an update code
   function automatic logic [8:0] nx(logic [8:0] s, logic [2:0] q, logic [7:0] t);
      case (q)
         3'h1: return s + 9'h1;
         3'h2: return s - 9'h1;
         3'h5: return s + {1'b0, t};
         default: return s - {1'b0, t};
      endcase
   endfunction
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Write strobe, then two edges so a step has landed
   task automatic wr(logic [7:0] a, logic [15:0] d);
      @(posedge mclk);
      riu_addr <= a;
      riu_wr_data <= d;
      riu_wr_en <= 1'b1;
      @(posedge mclk);
      riu_wr_en <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic rc(string nm, logic [7:0] a, logic [15:0] e);
      @(posedge mclk);
      riu_addr <= a;
      riu_rd_en <= 1'b1;
      @(posedge mclk);
      riu_rd_en <= 1'b0;
      #1;
      chk(nm, riu_rd_valid ? riu_rd_data : 16'hdead, e);
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Watchdog well beyond the expected run
   initial begin
      repeat (6000) @(posedge mclk);
      fails++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      rc("lane5", 8'h17, 16'h0000);
      rc("coarse", 8'h18, 16'h0000);
      rc("train", 8'h2b, 16'h0000);
      rc("idle", 8'h34, 16'h0010);
      rc("step", 8'h3b, 16'h0008);
      rc("unmapped", 8'h50, 16'h0000);
      $display("reset test done");
      // Every lane-5 code; wrap corners first, random starts later
      for (i = 0; i < 16; i++) begin
         if (i == 8) begin
            st = 8'(xs());
            wr(8'h3b, {8'hff, st});
            rc("step", 8'h3b, {8'h00, st});
         end
         rv = 16'(xs());
         c = cdt[i % 8];
         v = (i < 8) ? {9{c[0]}} : rv[15:7];
         wr(8'h17, {7'h00, v});
         v = (i % 8 > 3) ? nx(v, c, st) : rv[8:0];
         wr(8'h17, {c[0], c[1], c[2], 4'hf, rv[8:0]});
         chk("lane5", {7'h00, lane5_delay_value}, {7'h00, v});
         rc("lane5", 8'h17, {7'h00, v});
      end
      $display("lane5 test done");
      // Coarse codes; 0x1f up and 0 down wrap
      for (i = 0; i < 8; i++) begin
         rv = 16'(xs());
         k = 2'(i);
         b = (i < 4) ? {5{k[1]}} : rv[15:11];
         wr(8'h18, {11'h000, b});
         b = (k == 2'b10) ? b + 5'h1 : (k == 2'b01) ? b - 5'h1 : rv[4:0];
         wr(8'h18, {k, 9'h1ff, rv[4:0]});
         rc("coarse", 8'h18, {11'h000, b});
      end
      for (i = 0; i < 2; i++) begin
         wr(8'h2b, i ? 16'h0000 : 16'hffff);
         chk("train", {14'h0, drift_comp_enable, calibration_pause}, i ? 16'h0 : 16'h3);
         rc("train", 8'h2b, i ? 16'h0000 : 16'h0082);
      end
      // Fabric delay loads
      for (i = 0; i < 4; i++) begin
         v = 9'(xs());
         @(posedge mclk);
         fabric_delay_load <= 1'b1;
         fabric_delay_load_bus <= v;
         @(posedge mclk);
         fabric_delay_load <= 1'b0;
         @(posedge mclk);
         #1;
         chk("fabric", {7'h00, lane5_delay_value}, {7'h00, v});
      end
      $display("coarse, training, fabric tests done");
      wr(8'h34, 16'hffc3);
      rc("idle", 8'h34, 16'h0003);
      @(posedge mclk);
      read_active <= 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      chk("term_on", {15'h0, termination_enable}, 16'h1);
      @(posedge mclk);
      read_active <= 1'b0;
      #1;
      n = 0;
      // Count ticks taken while termination still stands
      for (i = 0; i < 200 && termination_enable === 1'b1; i++) begin
         n += rx_div_tick;
         @(posedge mclk);
         #1;
      end
      chk("idle_ticks", 16'(n), 16'h0004);
      $display("idle test done");
      close_out();
   end
endmodule // tb
`default_nettype wire
